//--- sync_serial_defs.vh
`ifndef SYNC_SERIAL_DEFS_VH
`define SYNC_SERIAL_DEFS_VH

// character lengths in data bits
`define SS_BITS_8        4'h8
`define SS_BITS_9        4'h9
// width of one stored character, ninth bit included
`define SS_CHAR_W        9
// receive buffer depth in characters
`define SS_RX_DEPTH      2
// occupancy at which the receive buffer is full, counter width
`define SS_RX_FULL       3'h2
// master shift clock: core clock cycles per half period
`define SS_MASTER_HALF   8'h04
// reset values
`define SS_CHAR_RST      9'h000
`define SS_CNT_RST       4'h0
`define SS_DIV_RST       8'h00
`define SS_BIT_RST       1'b0

`endif

//--- rx_char_buffer.v
// small receive buffer: shift-style queue, head held in a register
module rx_char_buffer #(
  parameter WIDTH = 9,                  // bits per stored character
  parameter DEPTH = 2                   // characters held
) (
  input  wire             clk,
  input  wire             rst,          // synchronous, active high
  input  wire             push,         // store wr_data at the tail
  input  wire [WIDTH-1:0] wr_data,
  input  wire             pop,          // drop the head
  output wire [WIDTH-1:0] head,         // oldest character, registered
  output reg  [DEPTH:0]   count         // characters stored
);

  // depth at the counter's own width, so compares need no slicing
  localparam [DEPTH:0] FULL = DEPTH;
  reg  [WIDTH-1:0] entry_q [0:DEPTH];   // one spare slot keeps index simple
  wire             do_push;             // push accepted only when room
  wire             do_pop;              // pop accepted only when data

  assign do_push = push & (count != FULL);
  assign do_pop  = pop & (count != {(DEPTH+1){1'b0}});
  assign head    = entry_q[0];

  // one register per entry; a pop shifts everything one place forward
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_entry
      localparam [DEPTH:0] IDX = i;     // slot index at counter width
      always @(posedge clk)
      begin
        if (rst)
          entry_q[i] <= {WIDTH{1'b0}};
        else if (do_pop)
        begin
          // tail slot after the shift takes the new character
          if (do_push && (count - 1'b1 == IDX))
            entry_q[i] <= wr_data;
          else
            entry_q[i] <= entry_q[i+1];
        end
        else if (do_push && (count == IDX))
          entry_q[i] <= wr_data;
      end
    end
  endgenerate

  // spare slot never holds data
  always @(posedge clk)
  begin
    entry_q[DEPTH] <= {WIDTH{1'b0}};
  end

  // occupancy
  always @(posedge clk)
  begin
    if (rst)
      count <= {(DEPTH+1){1'b0}};
    else if (do_push && !do_pop)
      count <= count + 1'b1;
    else if (do_pop && !do_push)
      count <= count - 1'b1;
  end

endmodule // rx_char_buffer

//--- sync_serial_master_rx_slave_sleep.v
`include "sync_serial_defs.vh"

module sync_serial_master_rx_slave_sleep #(
  parameter [7:0] MASTER_HALF = `SS_MASTER_HALF // core cycles per half clock
) (
  input  wire       CORE_CLK,
  input  wire       RST_N,
  input  wire       SERIAL_PORT_ENABLE,
  input  wire       SYNC_MODE_SELECT,
  input  wire       CLOCK_SOURCE_MASTER_SELECT,
  input  wire       SINGLE_RECEIVE_ENABLE,
  input  wire       CONTINUOUS_RECEIVE_ENABLE,
  input  wire       TRANSMIT_ENABLE,
  input  wire       NINE_BIT_TRANSMIT_SELECT,
  input  wire       TRANSMIT_NINTH_BIT,
  input  wire       NINE_BIT_RECEIVE_SELECT,
  input  wire       RECEIVE_INTERRUPT_ENABLE,
  input  wire       TRANSMIT_INTERRUPT_ENABLE,
  input  wire       PERIPHERAL_INTERRUPT_ENABLE,
  input  wire       SLEEP_ACTIVE,
  input  wire       TX_WRITE,
  input  wire [7:0] TX_WRITE_DATA,
  input  wire       RX_READ,
  input  wire       LINK_CLOCK_IN,
  input  wire       LINK_DATA_IN,
  output wire [7:0] RX_DATA,
  output wire       RECEIVE_NINTH_BIT,
  output reg        RECEIVE_COMPLETE_FLAG,
  output reg        OVERRUN_ERROR_FLAG,
  output reg        TRANSMIT_BUFFER_EMPTY_FLAG,
  output reg        TRANSMIT_SHIFT_EMPTY,
  output reg        RX_IRQ,
  output reg        TX_IRQ,
  output reg        WAKE_REQUEST,
  output reg        LINK_CLOCK_OUT,
  output reg        LINK_CLOCK_OE,
  output reg        LINK_DATA_OUT,
  output reg        LINK_DATA_OE
);

  // the port enable doubles as the reset of all but the link synchronisers
  wire       blk_rst;                   // synchronous block reset
  // mode decode
  wire       rx_mode;                   // any receive enable set
  wire       slave;                     // synchronous slave selected
  wire       master;                    // synchronous master selected
  wire       slave_tx;                  // slave transmit mode
  wire       slave_rx;                  // slave receive mode
  wire       master_run;                // master clock generator running
  wire       rx_run;                    // receiver accepting bits
  // link synchronisers and edges
  reg        lclk_s1_q;                 // first stage, read only by s2
  reg        lclk_s2_q;
  reg        lclk_s3_q;                 // previous synchronised level
  reg        ldat_s1_q;                 // first stage, read only by s2
  reg        ldat_s2_q;
  wire       lead;                      // leading (rising) clock edge
  wire       trail;                     // trailing (falling) clock edge
  // master clock generator
  reg  [7:0] div_q;                     // half period counter
  reg        mclk_q;                    // generated shift clock level
  wire       div_end;                   // half period elapsed
  // single-character request
  reg        single_receive_enable_prev_q;               // single enable, last cycle
  reg        single_q;                  // one character still owed
  // receiver
  reg  [8:0] rsr_q;                     // receive shift register
  reg  [3:0] rcnt_q;                    // bits taken this character
  wire [8:0] rsr_d;                     // shift register with new bit
  wire [8:0] rx_char;                   // character aligned to bit 0
  wire [3:0] rx_bits;                   // receive character length
  wire       rx_done;                   // last bit just sampled
  reg        ovr_q;                     // overrun, blocks reception
  reg        ovr_continuous_receive_enable_q;                // overrun hit in continuous mode
  wire       ovr_clr;                   // overrun clearing condition
  wire       push;                      // store a character
  wire       pop;                       // software read of the head
  wire [8:0] head;                      // oldest stored character
  wire [2:0] fill;                      // characters stored
  wire       rx_full;                   // no room for another
  // transmitter
  reg  [8:0] hold_q;                    // transmit holding register
  reg        hold_v_q;                  // holding register occupied
  reg  [8:0] tsr_q;                     // transmit shift register
  reg        tsr_v_q;                   // shift register occupied
  reg  [3:0] tcnt_q;                    // bits sent this character
  wire [3:0] tx_bits;                   // transmit character length
  wire       load;                      // holding to shift transfer

  assign blk_rst    = ~RST_N | ~SERIAL_PORT_ENABLE;
  assign rx_mode    = SINGLE_RECEIVE_ENABLE | CONTINUOUS_RECEIVE_ENABLE;
  assign slave      = SYNC_MODE_SELECT & ~CLOCK_SOURCE_MASTER_SELECT;
  assign master     = SYNC_MODE_SELECT & CLOCK_SOURCE_MASTER_SELECT;
  assign slave_tx   = slave & ~rx_mode & TRANSMIT_ENABLE;
  assign slave_rx   = slave & rx_mode;
  // master needs the core clock, so it halts while asleep
  assign master_run = master & ~SLEEP_ACTIVE & ~ovr_q
                    & (CONTINUOUS_RECEIVE_ENABLE | single_q);
  assign rx_run     = master_run | (slave_rx & ~ovr_q);
  assign div_end    = (div_q == MASTER_HALF - 8'h01);
  // slave edges come from the link clock; master from its own
  assign lead  = slave ? (lclk_s2_q & ~lclk_s3_q)
                       : (master_run & div_end & ~mclk_q);
  assign trail = slave ? (~lclk_s2_q & lclk_s3_q)
                       : (master_run & div_end & mclk_q);

  assign rx_bits = NINE_BIT_RECEIVE_SELECT ? `SS_BITS_9 : `SS_BITS_8;
  assign tx_bits = NINE_BIT_TRANSMIT_SELECT ? `SS_BITS_9 : `SS_BITS_8;
  // new bits enter at the top, so the first lands in bit 0 at the end
  assign rsr_d   = {ldat_s2_q, rsr_q[8:1]};
  assign rx_char = NINE_BIT_RECEIVE_SELECT ? rsr_d
                                           : {1'b0, rsr_d[8:1]};
  assign rx_done = rx_run & trail & (rcnt_q + 4'h1 == rx_bits);
  assign rx_full = (fill == `SS_RX_FULL);
  assign push    = rx_done & ~rx_full;
  assign pop     = RX_READ & (fill != 3'h0);
  // continuous overrun clears with its enable; single one by a read
  assign ovr_clr = ovr_continuous_receive_enable_q ? ~CONTINUOUS_RECEIVE_ENABLE : pop;
  assign load    = hold_v_q & ~tsr_v_q & slave_tx;

  assign RX_DATA           = head[7:0];
  assign RECEIVE_NINTH_BIT = head[8];

  // two-stage synchronisers on both link pins
  always @(posedge CORE_CLK)
  begin
    lclk_s1_q <= LINK_CLOCK_IN;
    lclk_s2_q <= lclk_s1_q;
    lclk_s3_q <= lclk_s2_q;
    ldat_s1_q <= LINK_DATA_IN;
    ldat_s2_q <= ldat_s1_q;
  end

  // master shift clock divider, idle low
  always @(posedge CORE_CLK)
  begin
    if (blk_rst || !master_run)
    begin
      // stopping mid-character drops the clock at once
      div_q  <= `SS_DIV_RST;
      mclk_q <= `SS_BIT_RST;
    end
    else if (div_end)
    begin
      div_q  <= `SS_DIV_RST;
      mclk_q <= ~mclk_q;
    end
    else
      div_q <= div_q + 8'h01;
  end

  // single enable arms one character, cleared when it is in
  always @(posedge CORE_CLK)
  begin
    if (blk_rst)
    begin
      single_receive_enable_prev_q <= `SS_BIT_RST;
      single_q    <= `SS_BIT_RST;
    end
    else
    begin
      single_receive_enable_prev_q <= SINGLE_RECEIVE_ENABLE;
      if (rx_done && master)
        single_q <= `SS_BIT_RST;
      else if (SINGLE_RECEIVE_ENABLE && !single_receive_enable_prev_q && master)
        single_q <= 1'b1;
    end
  end

  // receive shifter, sampled on the trailing edge
  always @(posedge CORE_CLK)
  begin
    if (blk_rst || !rx_run)
    begin
      // a partial character is discarded
      rsr_q  <= `SS_CHAR_RST;
      rcnt_q <= `SS_CNT_RST;
    end
    else if (trail)
    begin
      rsr_q <= rsr_d;
      if (rx_done)
        rcnt_q <= `SS_CNT_RST;
      else
        rcnt_q <= rcnt_q + 4'h1;
    end
  end

  // overrun: buffered data kept, reception held off until cleared
  always @(posedge CORE_CLK)
  begin
    if (blk_rst)
    begin
      ovr_q      <= `SS_BIT_RST;
      ovr_continuous_receive_enable_q <= `SS_BIT_RST;
    end
    else if (rx_done && rx_full)
    begin
      ovr_q      <= 1'b1;
      ovr_continuous_receive_enable_q <= CONTINUOUS_RECEIVE_ENABLE;
    end
    else if (ovr_q && ovr_clr)
      ovr_q <= `SS_BIT_RST;
  end

  rx_char_buffer #(
    .WIDTH (`SS_CHAR_W),
    .DEPTH (`SS_RX_DEPTH)
  ) u_rx_buf (
    .clk     (CORE_CLK),
    .rst     (blk_rst),
    .push    (push),
    .wr_data (rx_char),
    .pop     (pop),
    .head    (head),
    .count   (fill)
  );

  // holding register; a write always refills it
  always @(posedge CORE_CLK)
  begin
    if (blk_rst)
    begin
      hold_q   <= `SS_CHAR_RST;
      hold_v_q <= `SS_BIT_RST;
    end
    else if (TX_WRITE)
    begin
      // ninth bit is captured with the low byte
      hold_q   <= {TRANSMIT_NINTH_BIT, TX_WRITE_DATA};
      hold_v_q <= 1'b1;
    end
    else if (load)
      hold_v_q <= `SS_BIT_RST;
  end

  // transmit shifter; bit changes on the leading edge
  always @(posedge CORE_CLK)
  begin
    if (blk_rst || !TRANSMIT_ENABLE)
    begin
      tsr_q         <= `SS_CHAR_RST;
      tsr_v_q       <= `SS_BIT_RST;
      tcnt_q        <= `SS_CNT_RST;
      LINK_DATA_OUT <= `SS_BIT_RST;
    end
    else if (load)
    begin
      tsr_q   <= hold_q;
      tsr_v_q <= 1'b1;
      tcnt_q  <= `SS_CNT_RST;
    end
    else if (tsr_v_q && slave_tx && lead)
    begin
      LINK_DATA_OUT <= tsr_q[0];
      tsr_q         <= {1'b0, tsr_q[8:1]};
      tcnt_q        <= tcnt_q + 4'h1;
    end
    else if (tsr_v_q && slave_tx && trail && tcnt_q == tx_bits)
      tsr_v_q <= `SS_BIT_RST;
  end

  // pin drivers: clock out only as master, data out only in slave send
  always @(posedge CORE_CLK)
  begin
    if (blk_rst)
    begin
      LINK_CLOCK_OUT <= `SS_BIT_RST;
      LINK_CLOCK_OE  <= `SS_BIT_RST;
      LINK_DATA_OE   <= `SS_BIT_RST;
    end
    else
    begin
      LINK_CLOCK_OUT <= mclk_q;
      LINK_CLOCK_OE  <= master;
      LINK_DATA_OE   <= slave_tx;
    end
  end

  // flags, interrupt requests and wake-up, one cycle behind state
  always @(posedge CORE_CLK)
  begin
    if (blk_rst)
    begin
      RECEIVE_COMPLETE_FLAG      <= `SS_BIT_RST;
      OVERRUN_ERROR_FLAG         <= `SS_BIT_RST;
      TRANSMIT_BUFFER_EMPTY_FLAG <= `SS_BIT_RST;
      TRANSMIT_SHIFT_EMPTY       <= `SS_BIT_RST;
      RX_IRQ                     <= `SS_BIT_RST;
      TX_IRQ                     <= `SS_BIT_RST;
      WAKE_REQUEST               <= `SS_BIT_RST;
    end
    else
    begin
      // flag stays up while unread characters remain
      RECEIVE_COMPLETE_FLAG      <= (fill != 3'h0);
      OVERRUN_ERROR_FLAG         <= ovr_q;
      TRANSMIT_BUFFER_EMPTY_FLAG <= ~hold_v_q;
      TRANSMIT_SHIFT_EMPTY       <= ~tsr_v_q;
      RX_IRQ <= (fill != 3'h0) & RECEIVE_INTERRUPT_ENABLE;
      TX_IRQ <= ~hold_v_q & TRANSMIT_INTERRUPT_ENABLE
              & PERIPHERAL_INTERRUPT_ENABLE;
      WAKE_REQUEST <= SLEEP_ACTIVE
        & (((fill != 3'h0) & RECEIVE_INTERRUPT_ENABLE)
        | (~hold_v_q & TRANSMIT_INTERRUPT_ENABLE
           & PERIPHERAL_INTERRUPT_ENABLE));
    end
  end

endmodule // sync_serial_master_rx_slave_sleep

//--- serial_checker.sv
module serial_checker (
  input wire       CORE_CLK,
  input wire       RST_N,
  input wire       SERIAL_PORT_ENABLE,
  input wire       SYNC_MODE_SELECT,
  input wire       CLOCK_SOURCE_MASTER_SELECT,
  input wire       SINGLE_RECEIVE_ENABLE,
  input wire       CONTINUOUS_RECEIVE_ENABLE,
  input wire       TRANSMIT_ENABLE,
  input wire       RECEIVE_INTERRUPT_ENABLE,
  input wire       TRANSMIT_INTERRUPT_ENABLE,
  input wire       PERIPHERAL_INTERRUPT_ENABLE,
  input wire       SLEEP_ACTIVE,
  input wire       TX_WRITE,
  input wire       RX_READ,
  input wire [7:0] RX_DATA,
  input wire       RECEIVE_COMPLETE_FLAG,
  input wire       OVERRUN_ERROR_FLAG,
  input wire       TRANSMIT_BUFFER_EMPTY_FLAG,
  input wire       TRANSMIT_SHIFT_EMPTY,
  input wire       TX_IRQ,
  input wire       WAKE_REQUEST,
  input wire       LINK_CLOCK_OUT,
  input wire       LINK_DATA_OE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // slave transmit set-up, both receive enables clear
  wire slave_tx = SERIAL_PORT_ENABLE && SYNC_MODE_SELECT && TRANSMIT_ENABLE
    && !CLOCK_SOURCE_MASTER_SELECT && !SINGLE_RECEIVE_ENABLE
    && !CONTINUOUS_RECEIVE_ENABLE;
  // three edges covers the register lag of every output
  sequence s_held(x);
    x [*3];
  endsequence
  sequence s_cont_drop;
    !CLOCK_SOURCE_MASTER_SELECT && OVERRUN_ERROR_FLAG
      && CONTINUOUS_RECEIVE_ENABLE ##1 !CONTINUOUS_RECEIVE_ENABLE;
  endsequence
  sequence s_write_busy;
    TX_WRITE && TRANSMIT_BUFFER_EMPTY_FLAG && !TRANSMIT_SHIFT_EMPTY;
  endsequence
  chk_slave_tx_drive: assert property (s_held(slave_tx) |-> LINK_DATA_OE)
    else $error("data pin not driven in slave transmit");
  chk_tx_irq_follow: assert property (s_held(TRANSMIT_BUFFER_EMPTY_FLAG
    && TRANSMIT_INTERRUPT_ENABLE && PERIPHERAL_INTERRUPT_ENABLE) |-> TX_IRQ)
    else $error("transmit request missing");
  chk_wake_on_rx: assert property (s_held(SLEEP_ACTIVE && RECEIVE_COMPLETE_FLAG
    && RECEIVE_INTERRUPT_ENABLE) |-> WAKE_REQUEST)
    else $error("no wake on received word");
  chk_wake_asleep: assert property (WAKE_REQUEST |-> $past(SLEEP_ACTIVE))
    else $error("wake request while awake");
  chk_overrun_clear: assert property (s_cont_drop |-> ##[1:3] !OVERRUN_ERROR_FLAG)
    else $error("overrun kept after continuous clear");
  chk_port_off_clear: assert property (!SERIAL_PORT_ENABLE [*2] |->
    !RECEIVE_COMPLETE_FLAG && !OVERRUN_ERROR_FLAG && !LINK_DATA_OE)
    else $error("port disable did not clear block");
  chk_overrun_keeps: assert property (OVERRUN_ERROR_FLAG
    && $past(OVERRUN_ERROR_FLAG) && $past(SERIAL_PORT_ENABLE)
    && !$past(RX_READ) && !$past(RX_READ, 2) |-> $stable(RX_DATA))
    else $error("buffered data changed during overrun");
  chk_sleep_no_mclk: assert property (SLEEP_ACTIVE [*4] |->
    $stable(LINK_CLOCK_OUT))
    else $error("master clock ran while asleep");
  chk_write_fills: assert property (s_write_busy |->
    ##[1:3] !TRANSMIT_BUFFER_EMPTY_FLAG)
    else $error("empty flag stayed after write");
endmodule // serial_checker

bind sync_serial_master_rx_slave_sleep serial_checker u_chk (
  .CORE_CLK, .RST_N, .SERIAL_PORT_ENABLE, .SYNC_MODE_SELECT,
  .CLOCK_SOURCE_MASTER_SELECT, .SINGLE_RECEIVE_ENABLE,
  .CONTINUOUS_RECEIVE_ENABLE, .TRANSMIT_ENABLE, .RECEIVE_INTERRUPT_ENABLE,
  .TRANSMIT_INTERRUPT_ENABLE, .PERIPHERAL_INTERRUPT_ENABLE, .SLEEP_ACTIVE,
  .TX_WRITE, .RX_READ, .RX_DATA, .RECEIVE_COMPLETE_FLAG, .OVERRUN_ERROR_FLAG,
  .TRANSMIT_BUFFER_EMPTY_FLAG, .TRANSMIT_SHIFT_EMPTY, .TX_IRQ, .WAKE_REQUEST,
  .LINK_CLOCK_OUT, .LINK_DATA_OE
);

//--- link_master_model.sv
// far-side synchronous master: clock idles low between frames
module link_master_model (
  output logic link_clk,     // clock it drives
  output logic link_dat,     // data it drives
  input  wire  data_seen     // resolved data line
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 160; // half of the 320 ns link period
  initial
  begin
    link_clk = 1'b0;
    link_dat = 1'b1;
  end
  // line held by the far side while the block is master
  task automatic hold(input logic b);
    link_dat = b;
  endtask
  // one clock per bit, data set on the leading edge, lsb first
  task automatic send(input logic [8:0] v, input int n);
    #HALF;
    for (int i = 0; i < n; i++)
    begin
      link_clk = 1'b1;
      link_dat = v[i];
      #HALF link_clk = 1'b0;
      #HALF;
    end
    link_dat = ~link_dat; // released line never shows the stale bit
  endtask
  // sample late in the low phase, after the block has moved its bit
  task automatic recv(output logic [8:0] v, input int n);
    v = 9'h000;
    #HALF;
    for (int i = 0; i < n; i++)
    begin
      link_clk = 1'b1;
      #HALF link_clk = 1'b0;
      #(HALF - 10) v[i] = data_seen;
      #10;
    end
  endtask
endmodule // link_master_model

//--- sync_serial_master_rx_slave_sleep_bench.sv
module sync_serial_master_rx_slave_sleep_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       CORE_CLK, RST_N, SERIAL_PORT_ENABLE, SYNC_MODE_SELECT;
  logic       CLOCK_SOURCE_MASTER_SELECT, SINGLE_RECEIVE_ENABLE;
  logic       CONTINUOUS_RECEIVE_ENABLE, TRANSMIT_ENABLE, TX_WRITE, RX_READ;
  logic       NINE_BIT_TRANSMIT_SELECT, TRANSMIT_NINTH_BIT, SLEEP_ACTIVE;
  logic       NINE_BIT_RECEIVE_SELECT, RECEIVE_INTERRUPT_ENABLE;
  logic       TRANSMIT_INTERRUPT_ENABLE, PERIPHERAL_INTERRUPT_ENABLE;
  logic [7:0] TX_WRITE_DATA;
  wire  [7:0] RX_DATA;
  wire        RECEIVE_NINTH_BIT, RECEIVE_COMPLETE_FLAG, OVERRUN_ERROR_FLAG;
  wire        TRANSMIT_BUFFER_EMPTY_FLAG, TRANSMIT_SHIFT_EMPTY, RX_IRQ, TX_IRQ;
  wire        WAKE_REQUEST, LINK_CLOCK_OUT, LINK_CLOCK_OE, LINK_DATA_OUT;
  wire        LINK_DATA_OE, far_clk, far_dat;
  // wire levels resolved from whoever drives each pin
  wire        LINK_CLOCK_IN = LINK_CLOCK_OE ? LINK_CLOCK_OUT : far_clk;
  wire        LINK_DATA_IN  = LINK_DATA_OE ? LINK_DATA_OUT : far_dat;
  int         n_fail, checked, edges;
  logic [8:0] got;

  sync_serial_master_rx_slave_sleep uut (
    .CORE_CLK, .RST_N, .SERIAL_PORT_ENABLE, .SYNC_MODE_SELECT,
    .CLOCK_SOURCE_MASTER_SELECT, .SINGLE_RECEIVE_ENABLE,
    .CONTINUOUS_RECEIVE_ENABLE, .TRANSMIT_ENABLE, .NINE_BIT_TRANSMIT_SELECT,
    .TRANSMIT_NINTH_BIT, .NINE_BIT_RECEIVE_SELECT, .RECEIVE_INTERRUPT_ENABLE,
    .TRANSMIT_INTERRUPT_ENABLE, .PERIPHERAL_INTERRUPT_ENABLE, .SLEEP_ACTIVE,
    .TX_WRITE, .TX_WRITE_DATA, .RX_READ, .LINK_CLOCK_IN, .LINK_DATA_IN,
    .RX_DATA, .RECEIVE_NINTH_BIT, .RECEIVE_COMPLETE_FLAG, .OVERRUN_ERROR_FLAG,
    .TRANSMIT_BUFFER_EMPTY_FLAG, .TRANSMIT_SHIFT_EMPTY, .RX_IRQ, .TX_IRQ,
    .WAKE_REQUEST, .LINK_CLOCK_OUT, .LINK_CLOCK_OE, .LINK_DATA_OUT,
    .LINK_DATA_OE
  );
  link_master_model far (.link_clk(far_clk), .link_dat(far_dat),
    .data_seen(LINK_DATA_IN));

  // 25 MHz core clock
  initial
  begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end
  // master clock pulses counted for the clocks-per-character check
  always @(posedge LINK_CLOCK_OUT) edges++;
  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // bounded wait for the receive flag
  task automatic wait_rx;
    int i;
    for (i = 0; i < 600 && RECEIVE_COMPLETE_FLAG !== 1'b1; i++)
      cyc(1);
    if (i == 600)
    begin
      n_fail++;
      stop_test;
    end
  endtask
  // compare the head character, then pop it
  task automatic rd(input logic [8:0] exp);
    @(negedge CORE_CLK);
    chk({RECEIVE_NINTH_BIT, RX_DATA}, exp);
    cyc(1);
    RX_READ <= 1'b1;
    cyc(1);
    RX_READ <= 1'b0;
    cyc(3);
  endtask
  task automatic wr(input logic [7:0] d);
    TX_WRITE <= 1'b1;
    TX_WRITE_DATA <= d;
    cyc(1);
    TX_WRITE <= 1'b0;
    cyc(4);
  endtask
  // a hang counts as a mismatch
  initial
  begin
    #200000;
    n_fail++;
    stop_test;
  end
  initial
  begin
    {RST_N, SERIAL_PORT_ENABLE, CLOCK_SOURCE_MASTER_SELECT, TX_WRITE,
      SINGLE_RECEIVE_ENABLE, CONTINUOUS_RECEIVE_ENABLE, TRANSMIT_ENABLE,
      NINE_BIT_TRANSMIT_SELECT, TRANSMIT_NINTH_BIT, NINE_BIT_RECEIVE_SELECT,
      RECEIVE_INTERRUPT_ENABLE, TRANSMIT_INTERRUPT_ENABLE, RX_READ,
      PERIPHERAL_INTERRUPT_ENABLE, SLEEP_ACTIVE} <= '0;
    SYNC_MODE_SELECT <= 1'b1;
    TX_WRITE_DATA <= 8'h00;
    cyc(10);
    RST_N <= 1'b1;
    SERIAL_PORT_ENABLE <= 1'b1;
    CONTINUOUS_RECEIVE_ENABLE <= 1'b1;
    RECEIVE_INTERRUPT_ENABLE <= 1'b1;
    cyc(4);
    // slave receive: two stored, the third overruns
    far.send(9'h0a5, 8);
    wait_rx;
    @(negedge CORE_CLK);
    chk(RX_IRQ, 1'b1);
    far.send(9'h03c, 8);
    far.send(9'h0ff, 8);
    cyc(8);
    @(negedge CORE_CLK);
    chk(OVERRUN_ERROR_FLAG, 1'b1);
    chk(RX_DATA, 8'ha5);
    cyc(1);
    CONTINUOUS_RECEIVE_ENABLE <= 1'b0;
    cyc(4);
    @(negedge CORE_CLK);
    chk(OVERRUN_ERROR_FLAG, 1'b0);
    cyc(1);
    CONTINUOUS_RECEIVE_ENABLE <= 1'b1;
    rd(9'h0a5);
    rd(9'h03c);
    // nine-bit word received while asleep wakes the core
    NINE_BIT_RECEIVE_SELECT <= 1'b1;
    SINGLE_RECEIVE_ENABLE <= 1'b1;
    SLEEP_ACTIVE <= 1'b1;
    far.send(9'h1c3, 9);
    wait_rx;
    cyc(2);
    @(negedge CORE_CLK);
    chk(WAKE_REQUEST, 1'b1);
    cyc(1);
    SLEEP_ACTIVE <= 1'b0;
    SINGLE_RECEIVE_ENABLE <= 1'b0;
    rd(9'h1c3);
    // slave transmit: two words written, sent while asleep
    NINE_BIT_RECEIVE_SELECT <= 1'b0;
    CONTINUOUS_RECEIVE_ENABLE <= 1'b0;
    TRANSMIT_ENABLE <= 1'b1;
    TRANSMIT_INTERRUPT_ENABLE <= 1'b1;
    PERIPHERAL_INTERRUPT_ENABLE <= 1'b1;
    cyc(4);
    wr(8'h96);
    wr(8'h4b);
    @(negedge CORE_CLK);
    chk(TRANSMIT_BUFFER_EMPTY_FLAG, 1'b0);
    cyc(1);
    SLEEP_ACTIVE <= 1'b1;
    far.recv(got, 8);
    chk(got, 9'h096);
    cyc(8);
    @(negedge CORE_CLK);
    chk(TRANSMIT_BUFFER_EMPTY_FLAG, 1'b1);
    chk(WAKE_REQUEST, 1'b1);
    far.recv(got, 8);
    chk(got, 9'h04b);
    cyc(4);
    @(negedge CORE_CLK);
    chk(TRANSMIT_SHIFT_EMPTY, 1'b1);
    // nine-bit word: ninth bit set up before the low byte
    cyc(1);
    NINE_BIT_TRANSMIT_SELECT <= 1'b1;
    TRANSMIT_NINTH_BIT <= 1'b1;
    cyc(1);
    wr(8'h5a);
    far.recv(got, 9);
    chk(got, 9'h15a);
    cyc(4);
    NINE_BIT_TRANSMIT_SELECT <= 1'b0;
    TRANSMIT_NINTH_BIT <= 1'b0;
    // master single receive: eight clocks then one character
    cyc(1);
    SLEEP_ACTIVE <= 1'b0;
    TRANSMIT_ENABLE <= 1'b0;
    CLOCK_SOURCE_MASTER_SELECT <= 1'b1;
    far.hold(1'b1);
    cyc(4);
    edges = 0;
    SINGLE_RECEIVE_ENABLE <= 1'b1;
    wait_rx;
    cyc(40);
    @(negedge CORE_CLK);
    chk(LINK_CLOCK_OE, 1'b1);
    chk(edges[8:0], 9'h008);
    rd(9'h0ff);
    // asleep the master must not clock
    SINGLE_RECEIVE_ENABLE <= 1'b0;
    SLEEP_ACTIVE <= 1'b1;
    cyc(2);
    edges = 0;
    CONTINUOUS_RECEIVE_ENABLE <= 1'b1;
    cyc(60);
    chk(edges[8:0], 9'h000);
    SERIAL_PORT_ENABLE <= 1'b0;
    cyc(3);
    @(negedge CORE_CLK);
    chk(OVERRUN_ERROR_FLAG, 1'b0);
    stop_test;
  end
endmodule // sync_serial_master_rx_slave_sleep_bench
